/* sbm_regs.svh */
// register offsets, field positions, reset values and limits of the bus master
// register bank; included by the bank module, definitions only
// Function
// - Status bits 0, 1, 2 and 4 flag I/O timeout, driver fault, fatal bus error, slave timeout.
// - Status bit 5 sets when a remote read or write touches the remote config range.
// - Status bit 8 sets once every expansion module has been initialized.
// - Status bit 9 sets only while all gathered input data is valid.
// - Status bit 13 stays high as busy for the whole bus initialization.
// - Status bit 15 shows the hardware variant, 0 standard and 1 isolated.
// - The command register takes a code 0 to 255, reads back the last one, resets to 0.
// - Command 30 initializes, or fully re-initializes, all expansion modules.
// - Command 31 reads and command 32 writes a register of the remote config range.
// - The reduced bus status resets to 0; bit 3 is I/O timeout, bit 4 slave timeout.
// - Rate codes 4 to 7 give 125k to 1M baud, reset 7, applied at the next init.
`ifndef SBM_REGS_SVH
`define SBM_REGS_SVH

// byte offsets
`define SBM_OFF_STATUS   8'h00
`define SBM_OFF_COMMAND  8'h04
`define SBM_OFF_REDUCED  8'h08
`define SBM_OFF_RATE     8'h0C
`define SBM_OFF_RINDEX   8'h10
`define SBM_OFF_RDATA    8'h14

// status field positions
`define SBM_ST_IOTMO     0
`define SBM_ST_DRVERR    1
`define SBM_ST_FATAL     2
`define SBM_ST_SLVTMO    4
`define SBM_ST_CFGHIT    5
`define SBM_ST_ALLINIT   8
`define SBM_ST_INVALID   9
`define SBM_ST_BUSY      13
`define SBM_ST_VARIANT   15
`define SBM_RED_IOTMO    3
`define SBM_RED_SLVTMO   4

// command codes and reset values
`define SBM_CMD_INIT     8'h1E
`define SBM_CMD_RREAD    8'h1F
`define SBM_CMD_RWRITE   8'h20
`define SBM_CMD_RESET    8'h00
`define SBM_RATE_RESET   3'h7
`define SBM_RATE_MIN     3'h4

// remote configuration range, decimal 7000 to 7999
`define SBM_CFG_LO       16'h1B58
`define SBM_CFG_HI       16'h1F3F

`endif

/* sbm_pkg.sv */
// types shared by the bus master register bank
// assumes nothing of its surroundings
package sbm_pkg;

	// sequencer states of the bank
	typedef enum logic [1:0] {
		SBM_IDLE,
		SBM_INIT,
		SBM_REMOTE
	} sbm_state_t;

	// one-cycle error events from the bus engine
	typedef struct packed {
		logic ioTimeout;
		logic driverFault;
		logic fatalError;
		logic slaveTimeout;
	} sbm_events_t;

	// request to the bus engine for a remote register
	typedef struct packed {
		logic        read;
		logic        write;
		logic [15:0] index;
		logic [15:0] data;
	} sbm_remote_t;

endpackage : sbm_pkg

/* sbm_master_regs.sv */
// status, command and rate registers of the system bus master, APB slave
// assumes a bus engine on the same clock; only the variant strap is asynchronous
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sbm_regs.svh"

module sbm_master_regs #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// bus engine events and state
	input  wire sbm_pkg::sbm_events_t events,
	input  wire logic                allInitialized,
	input  wire logic                inputsValid,
	input  wire logic                initDone,
	input  wire logic                remoteDone,
	input  wire logic [15:0]         remoteReadData,
	// hardware variant strap pin
	input  wire logic                variantPin,
	// requests to the bus engine
	output logic                     initStart,
	output logic      [2:0]          baudCode,
	output sbm_pkg::sbm_remote_t     remoteReq
);

	//--------------------------------------------------------------
	// state
	//--------------------------------------------------------------
	sbm_pkg::sbm_state_t state;
	logic [7:0]  command;
	logic [2:0]  rateSel;
	logic [15:0] remoteIndex;
	logic [15:0] remoteData;
	logic [5:0]  errFlags;   // ioTmo, drvErr, fatal, -, slvTmo, cfgHit at their bit positions
	logic [4:3]  redFlags;
	logic        variantMeta;
	logic        variantSync;
	logic        variant;
	logic        variantTaken;
	logic [1:0]  strapAge;     // edges seen since reset, saturates at 2'h3

	// access decode
	logic        setupPhase;
	logic        wrAccess;
	logic        wrStatus;
	logic        wrCommand;
	logic        wrReduced;
	logic [7:0]  newCmd;
	logic        cfgHit;
	logic        busy;
	logic [15:0] statusWord;

	assign setupPhase = psel & ~penable;
	assign wrAccess   = psel & penable & pready & pwrite & ~pslverr;
	assign wrStatus   = wrAccess && paddr == ADDR_W'(`SBM_OFF_STATUS);
	assign wrCommand  = wrAccess && paddr == ADDR_W'(`SBM_OFF_COMMAND);
	assign wrReduced  = wrAccess && paddr == ADDR_W'(`SBM_OFF_REDUCED);
	assign newCmd     = pwdata[7:0];
	assign cfgHit     = remoteIndex >= `SBM_CFG_LO && remoteIndex <= `SBM_CFG_HI;
	assign busy       = state == sbm_pkg::SBM_INIT;

	// assembled interface status
	always_comb begin
		statusWord                   = 16'h0000;
		statusWord[5:0]              = errFlags;
		statusWord[`SBM_ST_ALLINIT]  = allInitialized & ~busy;
		statusWord[`SBM_ST_INVALID]  = inputsValid & ~busy;
		statusWord[`SBM_ST_BUSY]     = busy;
		statusWord[`SBM_ST_VARIANT]  = variant;
	end

	//--------------------------------------------------------------
	// apb answer: taken in setup, ready in the first access cycle
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setupPhase;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (setupPhase) begin
				case (paddr)
					ADDR_W'(`SBM_OFF_STATUS):  prdata[15:0] <= statusWord;
					ADDR_W'(`SBM_OFF_COMMAND): prdata[7:0]  <= command;
					ADDR_W'(`SBM_OFF_REDUCED): prdata[4:3]  <= redFlags;
					ADDR_W'(`SBM_OFF_RATE):    prdata[2:0]  <= rateSel;
					ADDR_W'(`SBM_OFF_RINDEX):  prdata[15:0] <= remoteIndex;
					ADDR_W'(`SBM_OFF_RDATA):   prdata[15:0] <= remoteData;
					default:                   pslverr      <= 1'b1;
				endcase
			end
		end
	end

	//--------------------------------------------------------------
	// variant strap: synchronised, caught once after reset
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			variantMeta  <= 1'b0;
			variantSync  <= 1'b0;
			variant      <= 1'b0;
			variantTaken <= 1'b0;
			strapAge     <= 2'h0;
		end else begin
			variantMeta <= variantPin;
			variantSync <= variantMeta;
			strapAge    <= {strapAge[0], 1'b1};
			// second flop holds the pin from the second edge on, so it is caught at the third
			if (strapAge[1] && !variantTaken) begin
				variant      <= variantSync;
				variantTaken <= 1'b1;
			end
		end
	end

	//--------------------------------------------------------------
	// command register, records every written code
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst)
			command <= `SBM_CMD_RESET;
		else if (wrCommand)
			command <= newCmd;
	end

	//--------------------------------------------------------------
	// rate select and the rate applied on the link
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			rateSel  <= `SBM_RATE_RESET;
			baudCode <= `SBM_RATE_RESET;
		end else begin
			// codes outside 4 to 7 are ignored
			if (wrAccess && paddr == ADDR_W'(`SBM_OFF_RATE) && pwdata[31:3] == 29'h0
			    && pwdata[2:0] >= `SBM_RATE_MIN)
				rateSel <= pwdata[2:0];
			if (wrCommand && newCmd == `SBM_CMD_INIT)
				baudCode <= rateSel;
		end
	end

	//--------------------------------------------------------------
	// remote index and data registers
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			remoteIndex <= 16'h0000;
			remoteData  <= 16'h0000;
		end else begin
			if (wrAccess && paddr == ADDR_W'(`SBM_OFF_RINDEX) && state != sbm_pkg::SBM_REMOTE)
				remoteIndex <= pwdata[15:0];
			if (state == sbm_pkg::SBM_REMOTE && remoteDone && remoteReq.read)
				remoteData <= remoteReadData;
			else if (wrAccess && paddr == ADDR_W'(`SBM_OFF_RDATA)
			         && state != sbm_pkg::SBM_REMOTE)
				remoteData <= pwdata[15:0];
		end
	end

	//--------------------------------------------------------------
	// sequencer: init and remote access
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state     <= sbm_pkg::SBM_IDLE;
			initStart <= 1'b0;
			remoteReq <= '0;
		end else begin
			initStart <= 1'b0;
			if (wrCommand && newCmd == `SBM_CMD_INIT) begin
				// also restarts a running init or abandons a remote access
				state     <= sbm_pkg::SBM_INIT;
				initStart <= 1'b1;
				remoteReq <= '0;
			end else begin
				case (state)
					sbm_pkg::SBM_IDLE: begin
						if (wrCommand && (newCmd == `SBM_CMD_RREAD
						    || newCmd == `SBM_CMD_RWRITE)) begin
							state           <= sbm_pkg::SBM_REMOTE;
							remoteReq.read  <= newCmd == `SBM_CMD_RREAD;
							remoteReq.write <= newCmd == `SBM_CMD_RWRITE;
							remoteReq.index <= remoteIndex;
							remoteReq.data  <= remoteData;
						end
					end
					sbm_pkg::SBM_INIT: begin
						if (initDone)
							state <= sbm_pkg::SBM_IDLE;
					end
					sbm_pkg::SBM_REMOTE: begin
						if (remoteDone) begin
							state     <= sbm_pkg::SBM_IDLE;
							remoteReq <= '0;
						end
					end
					default: state <= sbm_pkg::SBM_IDLE;
				endcase
			end
		end
	end

	//--------------------------------------------------------------
	// sticky error flags: set wins over a write-one acknowledge
	//--------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			errFlags <= 6'h00;
		end else begin
			if (wrStatus)
				errFlags <= errFlags & ~pwdata[5:0] & 6'h37;
			if (events.ioTimeout)
				errFlags[`SBM_ST_IOTMO] <= 1'b1;
			if (events.driverFault)
				errFlags[`SBM_ST_DRVERR] <= 1'b1;
			if (events.fatalError)
				errFlags[`SBM_ST_FATAL] <= 1'b1;
			if (events.slaveTimeout)
				errFlags[`SBM_ST_SLVTMO] <= 1'b1;
			if (state == sbm_pkg::SBM_IDLE && wrCommand && cfgHit
			    && (newCmd == `SBM_CMD_RREAD || newCmd == `SBM_CMD_RWRITE))
				errFlags[`SBM_ST_CFGHIT] <= 1'b1;
		end
	end

	// reduced status, same acknowledge scheme
	always_ff @(posedge clock) begin
		if (rst) begin
			redFlags <= 2'h0;
		end else begin
			if (wrReduced)
				redFlags <= redFlags & ~pwdata[4:3];
			if (events.ioTimeout)
				redFlags[`SBM_RED_IOTMO] <= 1'b1;
			if (events.slaveTimeout)
				redFlags[`SBM_RED_SLVTMO] <= 1'b1;
		end
	end

endmodule : sbm_master_regs
`default_nettype wire

/* sbm_regs_properties.sv */
// assertions on the ports of the bus master register bank
// bound to every sbm_master_regs instance, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "sbm_regs.svh"

module sbm_regs_properties #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic                 clock,
	input wire logic                 rst,
	// apb side
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [ADDR_W-1:0]    paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// engine side
	input wire logic                 remoteDone,
	input wire logic                 initStart,
	input wire logic [2:0]           baudCode,
	input wire sbm_pkg::sbm_remote_t remoteReq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// an accepted write to the command register
	logic cmdWr;
	assign cmdWr = psel && penable && pready && pwrite && paddr == `SBM_OFF_COMMAND;

	init_pulse_a: assert property (
		cmdWr && pwdata[7:0] == `SBM_CMD_INIT |=> initStart ##1 !initStart)
		else $error("init request missing after command");
	init_cause_a: assert property (
		initStart |-> $past(cmdWr && pwdata[7:0] == `SBM_CMD_INIT))
		else $error("init request without command");
	rate_apply_a: assert property ($changed(baudCode) |-> initStart)
		else $error("link rate changed outside init");
	rate_range_a: assert property (baudCode >= `SBM_RATE_MIN)
		else $error("link rate code out of range");
	remote_hold_a: assert property ((remoteReq.read || remoteReq.write) && !remoteDone
		|=> $stable(remoteReq) || initStart)
		else $error("remote request dropped early");
	rwrite_cause_a: assert property (
		$rose(remoteReq.write) |-> $past(cmdWr && pwdata[7:0] == `SBM_CMD_RWRITE))
		else $error("remote write without command");
	rread_cause_a: assert property (
		$rose(remoteReq.read) |-> $past(cmdWr && pwdata[7:0] == `SBM_CMD_RREAD))
		else $error("remote read without command");
	ready_setup_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("slave error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero outside access");
endmodule : sbm_regs_properties

bind sbm_master_regs sbm_regs_properties #(.ADDR_W(ADDR_W)) props (.clock(clock), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .remoteDone(remoteDone),
	.initStart(initStart), .baudCode(baudCode), .remoteReq(remoteReq));
`default_nettype wire

/* sbm_bus_engine_model.sv */
// behavioural bus engine: initializes modules and serves remote accesses
// same clock as the bank; read data is the inverted index
`timescale 1ns/1ps
`default_nettype none

module sbm_bus_engine_model #(
	parameter int INIT_CYC = 20,
	parameter int REM_CYC  = 5
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// requests from the bank
	input  wire logic                 initStart,
	input  wire sbm_pkg::sbm_remote_t remoteReq,
	// answers to the bank
	output logic                      allInitialized,
	output logic                      inputsValid,
	output logic                      initDone,
	output logic                      remoteDone,
	output logic [15:0]               remoteReadData
);
	int initCnt;
	int remCnt;

	// init span, states go low on every restart
	always_ff @(posedge clock) begin
		initDone <= (initCnt == 1);
		initCnt  <= (initCnt > 0) ? initCnt - 1 : 0;
		if (initCnt == 1) begin
			allInitialized <= 1'b1;
			inputsValid    <= 1'b1;
		end
		if (rst || initStart) begin
			initCnt        <= rst ? 0 : INIT_CYC;
			allInitialized <= 1'b0;
			inputsValid    <= 1'b0;
		end
	end

	// remote access span
	always_ff @(posedge clock) begin
		remoteDone <= 1'b0;
		remCnt     <= remCnt + 1;
		if (remCnt == REM_CYC)
			remoteDone <= 1'b1;
		if (rst || remoteDone || !(remoteReq.read || remoteReq.write))
			remCnt <= 0;
	end
	// data only meaningful with done, a moving pattern elsewhere
	assign remoteReadData = remoteDone ? ~remoteReq.index : 16'h5A5A ^ remCnt[15:0];
endmodule : sbm_bus_engine_model
`default_nettype wire

/* system_bus_master_control_regs_tb_top.sv */
// self-checking bench of the bus master register bank
// drives apb and error events, the engine model answers requests
`timescale 1ns/1ps
`default_nettype none
`include "sbm_regs.svh"

module system_bus_master_control_regs_tb_top;
	logic                 clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]           paddr = 8'h00;
	logic [31:0]          pwdata = 32'h0, prdata, rdata;
	logic                 pready, pslverr, serr, allInit, inValid, initDone, remDone, initStart;
	logic [15:0]          remData;
	logic                 variantPin = 1'b1;
	logic [2:0]           baudCode;
	sbm_pkg::sbm_events_t events = '0;
	sbm_pkg::sbm_remote_t remoteReq;
	int                   miscompares = 0, checks = 0;

	always #12.5 clock = ~clock;

	sbm_master_regs dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .events(events), .allInitialized(allInit), .inputsValid(inValid),
		.initDone(initDone), .remoteDone(remDone), .remoteReadData(remData),
		.variantPin(variantPin), .initStart(initStart), .baudCode(baudCode),
		.remoteReq(remoteReq));
	sbm_bus_engine_model engine (.clock(clock), .rst(rst), .initStart(initStart),
		.remoteReq(remoteReq), .allInitialized(allInit), .inputsValid(inValid),
		.initDone(initDone), .remoteDone(remDone), .remoteReadData(remData));

	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdata = prdata;
		serr  = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rdata);
	endtask : rd

	// poll until busy clear and modules up, then check status
	task automatic wait_ready();
		int n = 0;
		do apb(1'b0, `SBM_OFF_STATUS, 32'h0); while ((rdata & 32'h2300) !== 32'h0300 && n++ < 60);
		chk("status ready", 32'h8300, rdata);
	endtask : wait_ready

	task automatic test_reset();
		rd(`SBM_OFF_STATUS, 32'h8000, "status reset");
		rd(`SBM_OFF_COMMAND, 32'h0, "command reset");
		rd(`SBM_OFF_REDUCED, 32'h0, "reduced reset");
		rd(`SBM_OFF_RATE, 32'h7, "rate reset");
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, serr});
		$display("test_reset done");
	endtask : test_reset

	task automatic test_init();
		apb(1'b1, `SBM_OFF_RATE, 32'h4);
		apb(1'b1, `SBM_OFF_RATE, 32'h3);
		rd(`SBM_OFF_RATE, 32'h4, "rate readback");
		chk("rate before init", 32'h7, {29'h0, baudCode});
		repeat (2) begin
			apb(1'b1, `SBM_OFF_COMMAND, 32'h1E);
			rd(`SBM_OFF_STATUS, 32'hA000, "status busy");
			rd(`SBM_OFF_COMMAND, 32'h1E, "last command");
			wait_ready();
		end
		chk("rate after init", 32'h4, {29'h0, baudCode});
		$display("test_init done");
	endtask : test_init

	task automatic test_events();
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			events <= sbm_pkg::sbm_events_t'(4'h8 >> i);
			@(posedge clock);
			events <= '0;
		end
		rd(`SBM_OFF_STATUS, 32'h8317, "status flags");
		rd(`SBM_OFF_REDUCED, 32'h18, "reduced flags");
		apb(1'b1, `SBM_OFF_STATUS, 32'h17);
		apb(1'b1, `SBM_OFF_REDUCED, 32'h18);
		rd(`SBM_OFF_STATUS, 32'h8300, "status acked");
		rd(`SBM_OFF_REDUCED, 32'h0, "reduced acked");
		$display("test_events done");
	endtask : test_events

	task automatic test_remote();
		apb(1'b1, `SBM_OFF_RINDEX, 32'h1B58);
		apb(1'b1, `SBM_OFF_RDATA, 32'h55AA);
		apb(1'b1, `SBM_OFF_COMMAND, 32'h20);
		@(posedge clock);
		chk("remote write", {14'h0, 2'b01, 16'h1B58},
			{14'h0, remoteReq.read, remoteReq.write, remoteReq.index});
		chk("remote wdata", 32'h55AA, {16'h0, remoteReq.data});
		repeat (10) @(posedge clock);
		rd(`SBM_OFF_STATUS, 32'h8320, "range hit");
		apb(1'b1, `SBM_OFF_STATUS, 32'h20);
		apb(1'b1, `SBM_OFF_RINDEX, 32'h64);
		apb(1'b1, `SBM_OFF_COMMAND, 32'h1F);
		@(posedge clock);
		chk("remote read", {14'h0, 2'b10, 16'h0064},
			{14'h0, remoteReq.read, remoteReq.write, remoteReq.index});
		repeat (10) @(posedge clock);
		rd(`SBM_OFF_RDATA, 32'hFF9B, "remote data");
		rd(`SBM_OFF_STATUS, 32'h8300, "no range hit");
		$display("test_remote done");
	endtask : test_remote

	// mid-run reset with the standard variant strapped
	task automatic test_variant();
		@(posedge clock);
		{rst, variantPin} <= 2'b10;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		rd(`SBM_OFF_STATUS, 32'h0, "status standard");
		rd(`SBM_OFF_RATE, 32'h7, "rate after reset");
		chk("link rate reset", 32'h7, {29'h0, baudCode});
		$display("test_variant done");
	endtask : test_variant

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		complete_run();
	end

	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		test_reset();
		test_init();
		test_events();
		test_remote();
		test_variant();
		complete_run();
	end
endmodule : system_bus_master_control_regs_tb_top
`default_nettype wire
